// ---- test/testbench.sv ----
// testbench.sv: self-checking bench of the sequencer
// assumes short latch-off and soft-start counts, gate driver model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vsf_pkg::*;
    localparam int LC = 20;
    localparam int SS = 2;
    logic core_clk = 0, arst_n = 0, enable = 0, p2 = 0, p3 = 0, supply_ok = 0;
    logic [2:0] pwm_req = '0, phase_level, phase_mid, phase_oe;
    logic [7:0] target_code = 8'h10, uv_set = '0, ref_code, uv_margin;
    logic uv_ovr = 0, oc_lim = 0, oc_high = 0, uv = 0, ov = 0;
    logic drv_line, drv_oe, ov_abs_sel, pg, oc_fault, ov_fault;
    vsf_phcnt_t phase_count;
    int errors = 0, compares = 0, seed = 32'hace2, n;
    always #5 core_clk = ~core_clk;
    vsf_gate_drv i_vsf_gate_drv (.core_clk(core_clk), .arst_n(arst_n),
        .supply_ok(supply_ok), .dev_pull(drv_oe), .line(drv_line));
    vsf_sequencer #(.LATCH_CYCLES(LC), .SS_DIV(SS)) i_vsf_sequencer (
        .core_clk(core_clk), .arst_n(arst_n), .enable(enable),
        .phase_two_sense_input(p2), .phase_three_sense_input(p3),
        .driver_on_line_i(drv_line), .driver_on_line_o(), .driver_on_line_oe(drv_oe),
        .pwm_req(pwm_req), .target_code(target_code), .undervoltage_margin_setting(uv_set),
        .uv_margin_override(uv_ovr), .oc_limit_cmp(oc_lim), .oc_high_cmp(oc_high),
        .undervoltage_detect(uv), .overvoltage_cmp(ov), .phase_level(phase_level),
        .phase_mid(phase_mid), .phase_oe(phase_oe), .test_current_en(),
        .ref_code(ref_code), .uv_margin(uv_margin), .ov_abs_sel(ov_abs_sel),
        .regulator_power_good(pg), .phase_count(phase_count), .oc_fault(oc_fault),
        .ov_fault(ov_fault));
    // *****************************************
    // helpers
    // *****************************************
    task cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cyc
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares += 1;
        if (e !== s) begin
            errors += 1;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [1:0] exp_cnt(input logic a, input logic b);
        return a ? (b ? 2'h1 : 2'h2) : 2'h3;
    endfunction : exp_cnt
    // reset with given straps, then margin setting checks
    task boot(input logic a, input logic b);
        arst_n = 0;
        p2 = a;
        p3 = b;
        cyc(4);
        arst_n = 1;
        cyc(20);
        chk("count", exp_cnt(a, b), phase_count);
        chk("fit", (1 << exp_cnt(a, b)) - 1, phase_oe & phase_mid);
        uv_ovr = 1;
        uv_set = 8'($random(seed));
        cyc(2);
        chk("uvm", uv_set, uv_margin);
        uv_ovr = 0;
        cyc(2);
        chk("uvdef", 8'h1e, uv_margin);
    endtask : boot
    // enable and wait for the ramp to reach target
    task go();
        enable = 1;
        for (n = 0; n < 999 && ref_code !== target_code; n++) cyc(1);
        cyc(3);
        chk("pg", 1, pg);
    endtask : go
    task close_out();
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        #300000;
        errors += 1;
        close_out();
    end
    // *****************************************
    // main sequence
    // *****************************************
    initial begin
        for (int k = 0; k < 4; k++) boot(k < 2, k % 2 == 0);
        target_code = {3'h0, 5'($random(seed))} | 8'h10;
        enable = 1;
        cyc(12);
        chk("held", 0, ref_code);
        chk("held_mid", 3'h7, phase_mid & phase_oe);
        chk("abs_on", 1, ov_abs_sel);
        supply_ok = 1;
        go();
        chk("ramp", 1, n >= SS * target_code && n <= SS * target_code + 12);
        chk("abs_off", 0, ov_abs_sel);
        pwm_req = 3'h1;
        cyc(2);
        chk("mid1", 3'h6, phase_mid);
        pwm_req = 3'h7;
        cyc(2);
        for (int k = 0; k < 16; k++) begin
            pwm_req = 3'($random(seed));
            cyc(1);
            chk("level", pwm_req, phase_level & phase_oe & ~phase_mid);
        end
        pwm_req = '0;
        uv = 1;
        cyc(6);
        chk("uv_pg", 0, pg);
        uv = 0;
        oc_lim = 1;
        cyc(LC - 6);
        oc_lim = 0;
        cyc(4);
        chk("oc_short", 0, oc_fault);
        oc_lim = 1;
        cyc(LC + 8);
        chk("oc_long", 1, oc_fault);
        chk("oc_oe", 0, phase_oe);
        oc_lim = 0;
        cyc(5);
        chk("oc_keep", 1, oc_fault);
        enable = 0;
        cyc(3);
        chk("oc_clr", 0, oc_fault);
        chk("dis_mid", 3'h7, phase_mid & phase_oe);
        go();
        oc_high = 1;
        cyc(5);
        chk("oc_high", 1, oc_fault);
        oc_high = 0;
        enable = 0;
        cyc(3);
        go();
        pwm_req = 3'h7;
        ov = 1;
        cyc(5);
        chk("ov", 12'he00, {phase_oe, phase_mid, phase_level, 2'b0, pg});
        ov = 0;
        cyc(SS * target_code + 10);
        chk("ov_ref", 0, ref_code);
        chk("ov_keep", 1, ov_fault);
        close_out();
    end
endmodule : testbench
`default_nettype wire

// ---- test/vsf_gate_drv.sv ----
// vsf_gate_drv.sv: behavioural gate driver on the driver-on wire
// assumes an open-drain wire with pull-up, released when nobody pulls
`timescale 1ns/1ps
`default_nettype none
module vsf_gate_drv #(
    parameter int HOLD = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic supply_ok,
    input wire logic dev_pull,
    output logic line
);
    int cnt_ff;
    // *****************************************
    // undervoltage hold-off of the driver side
    // *****************************************
    // restart the minimum low period while supply is short
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= HOLD;
        end else if (!supply_ok) begin
            cnt_ff <= HOLD;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // wired level: low if either party pulls
    assign line = !(dev_pull || cnt_ff != 0);
endmodule : vsf_gate_drv
`default_nettype wire

// ---- test/vsf_sequencer_asserts.sv ----
// vsf_sequencer_asserts.sv: port checker of the sequencer
// assumes binding onto vsf_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module vsf_sequencer_asserts
    import vsf_pkg::*;
#(
    parameter int NPH = 3,
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic phase_two_sense_input,
    input wire logic phase_three_sense_input,
    input wire logic undervoltage_detect,
    input wire logic driver_on_line_oe,
    input wire logic test_current_en,
    input wire logic [NPH-1:0] phase_level,
    input wire logic [NPH-1:0] phase_mid,
    input wire logic [NPH-1:0] phase_oe,
    input wire logic [DW-1:0] ref_code,
    input wire logic regulator_power_good,
    input wire vsf_pkg::vsf_phcnt_t phase_count,
    input wire logic oc_fault,
    input wire logic ov_fault
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // *****************************************
    // start-up, phase and fault relations
    // *****************************************
    a_cfg_open: assert property (
        test_current_en |-> phase_oe == '0) else $error("phase driven in config");
    a_count_det: assert property (
        $fell(test_current_en) |-> phase_count == (phase_two_sense_input ?
        (phase_three_sense_input ? 2'h1 : 2'h2) : 2'h3)) else $error("phase count wrong");
    a_count_held: assert property (
        !test_current_en |=> $stable(phase_count)) else $error("phase count moved");
    a_mid_first: assert property (
        $fell(driver_on_line_oe) |-> phase_oe != '0 && (phase_oe & ~phase_mid) == '0)
        else $error("driver line released before mid");
    a_ref_step: assert property (
        $changed(ref_code) && ref_code != '0 |-> ref_code == $past(ref_code) + 1'b1
        || ref_code == $past(ref_code) - 1'b1) else $error("reference jumped");
    a_disable_mid: assert property (
        !enable [*3] |-> (phase_oe & ~phase_mid) == '0) else $error("phase driven off");
    a_oc_open: assert property (
        oc_fault && $past(oc_fault) |-> phase_oe == '0 && !regulator_power_good)
        else $error("outputs alive after overload");
    a_oc_latch: assert property (
        oc_fault && enable |=> oc_fault) else $error("overload latch lost");
    a_ov_lows: assert property (
        ov_fault && $past(ov_fault) |-> phase_mid == '0 && phase_level == '0
        && phase_oe != '0 && !regulator_power_good) else $error("overvoltage outputs wrong");
    a_ov_latch: assert property (
        ov_fault && enable |=> ov_fault) else $error("overvoltage latch lost");
    a_uv_pg: assert property (
        undervoltage_detect [*5] |-> !regulator_power_good) else $error("pg high in uv");
    c_oc: cover property ($rose(oc_fault));
    c_ov: cover property ($rose(ov_fault));
    c_pg: cover property ($rose(regulator_power_good));
endmodule : vsf_sequencer_asserts
bind vsf_sequencer vsf_sequencer_asserts #(.NPH(NPH), .DW(DW)) i_vsf_sequencer_asserts (
    .core_clk, .arst_n, .enable, .phase_two_sense_input, .phase_three_sense_input,
    .undervoltage_detect, .driver_on_line_oe, .test_current_en, .phase_level,
    .phase_mid, .phase_oe, .ref_code, .regulator_power_good, .phase_count,
    .oc_fault, .ov_fault);
`default_nettype wire

// ---- verilog/vsf_defines.svh ----
// vsf_defines.svh: constants of the start-up and fault sequencer
// assumes a 100 MHz core clock; included by bare name
`ifndef VSF_DEFINES_SVH
`define VSF_DEFINES_SVH
// ****************************************
// timing
// ****************************************
`define VSF_CLK_MHZ 100
`define VSF_LATCH_US 50
`define VSF_LATCH_CYC (`VSF_LATCH_US * `VSF_CLK_MHZ)
`define VSF_CFG_CYC 16
`define VSF_SS_DIV 100
// ****************************************
// phase count codes and thresholds
// ****************************************
`define VSF_PH_THREE 2'h3
`define VSF_PH_TWO 2'h2
`define VSF_PH_ONE 2'h1
`define VSF_UV_MARGIN_MV 300
`define VSF_UV_LSB_MV 10
`define VSF_UV_MARGIN_DEF (`VSF_UV_MARGIN_MV / `VSF_UV_LSB_MV)
`define VSF_OV_MARGIN_MV 400
`define VSF_OV_ABS_MV 2900
`endif

// ---- verilog/vsf_pkg.sv ----
// vsf_pkg.sv: types of the start-up and fault sequencer
// assumes vsf_defines.svh for the numeric constants
`default_nettype none
package vsf_pkg;
    typedef enum logic [6:0] {
        VSF_CFG = 7'h01,
        VSF_IDLE = 7'h02,
        VSF_DRV = 7'h04,
        VSF_SOFT = 7'h08,
        VSF_RUN = 7'h10,
        VSF_OCP = 7'h20,
        VSF_OVP = 7'h40
    } vsf_state_e;
    typedef logic [1:0] vsf_phcnt_t;
endpackage : vsf_pkg
`default_nettype wire

// ---- verilog/vsf_sequencer.sv ----
// vsf_sequencer.sv: phase detect, soft start, phase output states, faults
// assumes synchronous straps and enable, asynchronous fault comparators
//
// What this block does
// - no sense strap high: three phases
// - only phase two strap high: two phases
// - both straps high: single phase
// - phase count sampled once before regulation
// - phases driven independently, overlap allowed
// - no start while driver line held low
// - held-off start puts phases mid first
// - soft start counts reference up stepwise
// - power-up: outputs open, test current on
// - mid level first, then driver-on asserted
// - phase leaves mid on first pulse
// - enable low returns phases to mid
// - overload persisting latch-off time shuts down
// - high current limit shuts down at once
// - current latch cleared by enable toggle
// - undervoltage drops power good
// - undervoltage margin replaceable by setting
// - overvoltage drops power good, ramps down
// - overvoltage: high sides off, lows on
// - overvoltage latched until enable toggle
// - absolute overvoltage threshold during start-up
`timescale 1ns/1ps
`default_nettype none
`include "vsf_defines.svh"
module vsf_sequencer #(
    parameter int NPH = 3,
    parameter int DW = 8,
    parameter int LATCH_CYCLES = `VSF_LATCH_CYC,
    parameter int SS_DIV = `VSF_SS_DIV
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic phase_two_sense_input,
    input wire logic phase_three_sense_input,
    input wire logic driver_on_line_i,
    output logic driver_on_line_o,
    output logic driver_on_line_oe,
    input wire logic [NPH-1:0] pwm_req,
    input wire logic [DW-1:0] target_code,
    input wire logic [7:0] undervoltage_margin_setting,
    input wire logic uv_margin_override,
    input wire logic oc_limit_cmp,
    input wire logic oc_high_cmp,
    input wire logic undervoltage_detect,
    input wire logic overvoltage_cmp,
    output logic [NPH-1:0] phase_level,
    output logic [NPH-1:0] phase_mid,
    output logic [NPH-1:0] phase_oe,
    output logic test_current_en,
    output logic [DW-1:0] ref_code,
    output logic [7:0] uv_margin,
    output logic ov_abs_sel,
    output logic regulator_power_good,
    output vsf_pkg::vsf_phcnt_t phase_count,
    output logic oc_fault,
    output logic ov_fault
);
    import vsf_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    // mask of fitted phases for a count code
    function automatic logic [NPH-1:0] ph_mask(input vsf_phcnt_t cnt);
        logic [NPH-1:0] m;
        m = '0;
        for (int i = 0; i < NPH; i++) begin
            if (i < int'(cnt)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : ph_mask

    // ****************************************
    // fault synchronisers
    // ****************************************
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic oc_lim_s;
    logic oc_high_s;
    logic uv_s;
    logic ov_s;

    // two-flop capture of comparator levels
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
        end else begin
            meta_ff <= {oc_limit_cmp, oc_high_cmp, undervoltage_detect, overvoltage_cmp};
            sync_ff <= meta_ff;
        end
    end

    assign oc_lim_s = sync_ff[3];
    assign oc_high_s = sync_ff[2];
    assign uv_s = sync_ff[1];
    assign ov_s = sync_ff[0];

    // ****************************************
    // sequencer state
    // ****************************************
    vsf_state_e state_ff;
    vsf_state_e nxt_state;
    logic [4:0] cfg_cnt_ff;
    logic [4:0] nxt_cfg_cnt;
    logic [15:0] ss_div_ff;
    logic [15:0] nxt_ss_div;
    logic [15:0] oc_cnt_ff;
    logic [15:0] nxt_oc_cnt;
    logic [NPH-1:0] started_ff;
    logic [NPH-1:0] nxt_started;
    vsf_phcnt_t phcnt_ff;
    vsf_phcnt_t nxt_phcnt;
    logic [DW-1:0] ref_ff;
    logic [DW-1:0] nxt_ref;
    logic step;
    logic [NPH-1:0] fitted;

    assign fitted = ph_mask(phcnt_ff);
    assign step = (ss_div_ff == 16'(SS_DIV - 1));

    // next state, counters and reference
    always_comb begin
        nxt_state = state_ff;
        nxt_cfg_cnt = cfg_cnt_ff;
        nxt_phcnt = phcnt_ff;
        nxt_ref = ref_ff;
        nxt_started = started_ff;
        nxt_oc_cnt = 16'h0000;
        nxt_ss_div = step ? 16'h0000 : 16'(ss_div_ff + 16'h0001);
        case (state_ff)
            VSF_CFG: begin
                // collect straps while outputs float
                nxt_cfg_cnt = 5'(cfg_cnt_ff + 5'h01);
                if (cfg_cnt_ff == 5'(`VSF_CFG_CYC - 1)) begin
                    if (phase_two_sense_input && phase_three_sense_input) begin
                        nxt_phcnt = `VSF_PH_ONE;
                    end else if (phase_two_sense_input) begin
                        nxt_phcnt = `VSF_PH_TWO;
                    end else begin
                        nxt_phcnt = `VSF_PH_THREE;
                    end
                    nxt_state = VSF_IDLE;
                end
            end
            VSF_IDLE: begin
                nxt_ref = '0;
                nxt_started = '0;
                if (enable) begin
                    nxt_state = VSF_DRV;
                end
            end
            VSF_DRV: begin
                // phases sit mid until the driver reports ready
                if (!enable) begin
                    nxt_state = VSF_IDLE;
                end else if (driver_on_line_i) begin
                    nxt_state = VSF_SOFT;
                    nxt_ss_div = 16'h0000;
                end
            end
            VSF_SOFT, VSF_RUN: begin
                nxt_started = started_ff | (pwm_req & fitted);
                if (step && ref_ff < target_code) begin
                    nxt_ref = DW'(ref_ff + 1'b1);
                end else if (step && ref_ff > target_code) begin
                    nxt_ref = DW'(ref_ff - 1'b1);
                end
                if (state_ff == VSF_SOFT && ref_ff == target_code) begin
                    nxt_state = VSF_RUN;
                end
                if (oc_lim_s) begin
                    nxt_oc_cnt = 16'(oc_cnt_ff + 16'h0001);
                end
                if (!enable) begin
                    nxt_state = VSF_IDLE;
                end else if (ov_s) begin
                    nxt_state = VSF_OVP;
                end else if (oc_high_s) begin
                    nxt_state = VSF_OCP;
                end else if (oc_lim_s && oc_cnt_ff == 16'(LATCH_CYCLES - 1)) begin
                    nxt_state = VSF_OCP;
                end
            end
            VSF_OCP: begin
                if (!enable) begin
                    nxt_state = VSF_IDLE;
                end
            end
            VSF_OVP: begin
                if (step && ref_ff != '0) begin
                    nxt_ref = DW'(ref_ff - 1'b1);
                end
                if (!enable) begin
                    nxt_state = VSF_IDLE;
                end
            end
            default: begin
                nxt_state = VSF_CFG;
            end
        endcase
    end

    // register sequencer state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= VSF_CFG;
            cfg_cnt_ff <= 5'h00;
            phcnt_ff <= `VSF_PH_THREE;
            ref_ff <= '0;
            started_ff <= '0;
            oc_cnt_ff <= 16'h0000;
            ss_div_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cfg_cnt_ff <= nxt_cfg_cnt;
            phcnt_ff <= nxt_phcnt;
            ref_ff <= nxt_ref;
            started_ff <= nxt_started;
            oc_cnt_ff <= nxt_oc_cnt;
            ss_div_ff <= nxt_ss_div;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    logic [NPH-1:0] lvl_ff;
    logic [NPH-1:0] nxt_lvl;
    logic [NPH-1:0] mid_ff;
    logic [NPH-1:0] nxt_mid;
    logic [NPH-1:0] oe_ff;
    logic [NPH-1:0] nxt_oe;
    logic test_ff;
    logic nxt_test;
    logic drv_rel_ff;
    logic nxt_drv_rel;
    logic pg_ff;
    logic nxt_pg;
    logic abs_ff;
    logic nxt_abs;
    logic [7:0] uvm_ff;
    logic [7:0] nxt_uvm;
    logic [NPH-1:0] nfit;

    assign nfit = ph_mask(nxt_phcnt);

    // output values follow the next state
    always_comb begin
        nxt_lvl = '0;
        nxt_mid = '0;
        nxt_oe = '0;
        nxt_test = 1'b0;
        nxt_drv_rel = 1'b0;
        nxt_pg = 1'b0;
        nxt_abs = 1'b1;
        nxt_uvm = uv_margin_override ? undervoltage_margin_setting : 8'(`VSF_UV_MARGIN_DEF);
        case (nxt_state)
            VSF_CFG: begin
                nxt_test = 1'b1;
            end
            VSF_IDLE, VSF_DRV: begin
                nxt_mid = nfit;
                nxt_oe = nfit;
                nxt_drv_rel = (nxt_state == VSF_DRV) && (state_ff == VSF_DRV);
            end
            VSF_SOFT, VSF_RUN: begin
                nxt_oe = nfit;
                nxt_mid = nfit & ~nxt_started;
                nxt_lvl = nfit & nxt_started & pwm_req;
                nxt_drv_rel = 1'b1;
                nxt_abs = (nxt_state == VSF_SOFT);
                nxt_pg = (nxt_state == VSF_RUN) && !uv_s;
            end
            VSF_OCP: begin
                nxt_oe = '0;
            end
            VSF_OVP: begin
                nxt_oe = nfit;
                nxt_lvl = '0;
                nxt_drv_rel = 1'b1;
                nxt_abs = 1'b0;
            end
            default: begin
                nxt_test = 1'b1;
            end
        endcase
    end

    // register the outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_ff <= '0;
            mid_ff <= '0;
            oe_ff <= '0;
            test_ff <= 1'b1;
            drv_rel_ff <= 1'b0;
            pg_ff <= 1'b0;
            abs_ff <= 1'b1;
            uvm_ff <= 8'(`VSF_UV_MARGIN_DEF);
        end else begin
            lvl_ff <= nxt_lvl;
            mid_ff <= nxt_mid;
            oe_ff <= nxt_oe;
            test_ff <= nxt_test;
            drv_rel_ff <= nxt_drv_rel;
            pg_ff <= nxt_pg;
            abs_ff <= nxt_abs;
            uvm_ff <= nxt_uvm;
        end
    end

    // driver-on is open drain: pulled low until released
    assign driver_on_line_o = 1'b0;
    assign driver_on_line_oe = ~drv_rel_ff;
    assign phase_level = lvl_ff;
    assign phase_mid = mid_ff;
    assign phase_oe = oe_ff;
    assign test_current_en = test_ff;
    assign ref_code = ref_ff;
    assign uv_margin = uvm_ff;
    assign ov_abs_sel = abs_ff;
    assign regulator_power_good = pg_ff;
    assign phase_count = phcnt_ff;
    assign oc_fault = (state_ff == VSF_OCP);
    assign ov_fault = (state_ff == VSF_OVP);
endmodule : vsf_sequencer
`default_nettype wire
